// ==== design/rasc_consts.svh ====
// constants for the relay array switch control block
`ifndef RASC_CONSTS_SVH
`define RASC_CONSTS_SVH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define RASC_OFF_CTRL      12'h000
`define RASC_OFF_MODE      12'h004
`define RASC_OFF_CMD       12'h008
`define RASC_OFF_STATUS    12'h00C
`define RASC_OFF_STATE_LO  12'h010
`define RASC_OFF_STATE_HI  12'h014
`define RASC_OFF_WATCH     12'h018
`define RASC_OFF_WDATA     12'h01C
`define RASC_OFF_PORTIO    12'h020
// ------------------------------------------------------------
// field positions and values
// ------------------------------------------------------------
`define RASC_CTRL_SLOTRST  0
`define RASC_CTRL_SYSRST   1
`define RASC_CMD_CLOSE     0
`define RASC_CMD_GO        1
`define RASC_CMD_MASK_LSB  8
`define RASC_WATCH_NONE    32'hFFFF_FFFF
`define RASC_MODE_RESET    2'h1
`define RASC_ROW_ZERO      2'h0
`define RASC_COIL_PULSE    8'h04
`endif

// ==== design/rasc_pkg.sv ====
// type definitions for the relay array switch control block
package rasc_pkg;
   // ------------------------------------------------------------
   // wiring modes of the multiplexer
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      one_wire_mode      = 2'b00,
      two_wire_mode      = 2'b01,
      dual_two_wire_mode = 2'b10,
      four_wire_mode     = 2'b11
   } rasc_mode_t;
   // ------------------------------------------------------------
   // bank sequencer states
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      RASC_IDLE  = 2'b00,
      RASC_SETUP = 2'b01,
      RASC_DRIVE = 2'b10,
      RASC_NEXT  = 2'b11
   } rasc_state_t;
endpackage : rasc_pkg

// ==== design/rasc_sync.sv ====
// two flip-flop synchroniser for a level input
`timescale 1ns/1ps
module rasc_sync (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic clk_en,
   // level
   input  wire logic din,
   output logic      dout
);
   logic meta;
   logic next_meta;
   logic next_dout;

   // ------------------------------------------------------------
   // stage logic
   // ------------------------------------------------------------
   // first stage is read only by the second
   always_comb begin
      next_meta = clk_en ? din : meta;
      next_dout = clk_en ? meta : dout;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= 1'b0;
         dout <= 1'b0;
      end else begin
         meta <= next_meta;
         dout <= next_dout;
      end
   end
endmodule : rasc_sync

// ==== design/rasc_watch.sv ====
// channel watch store: target and digital port history
`timescale 1ns/1ps
module rasc_watch
   import rasc_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   input  wire logic        clr,
   // command strobes
   input  wire logic        set_target,
   input  wire logic [31:0] target_in,
   input  wire logic        port_op,
   input  wire logic        port_hi,
   input  wire logic        port_wr,
   input  wire logic [7:0]  port_data,
   // results
   output logic [31:0]      target,
   output logic [17:0]      port_view
);
`include "rasc_consts.svh"
   logic [31:0] next_target;
   logic [17:0] next_port_view;

   // ------------------------------------------------------------
   // watch target and port records
   // ------------------------------------------------------------
   // view = {hi_wr, hi_data, lo_wr, lo_data}; hi port is lo port plus one
   always_comb begin
      next_target    = target;
      next_port_view = port_view;
      if (clr) begin
         next_target    = `RASC_WATCH_NONE;
         next_port_view = '0;
      end else begin
         if (set_target) begin
            next_target = target_in;
         end
         if (port_op && port_hi) begin
            next_port_view[17:9] = {port_wr, port_data};
         end else if (port_op) begin
            next_port_view[8:0] = {port_wr, port_data};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         target    <= `RASC_WATCH_NONE;
         port_view <= '0;
      end else if (clk_en) begin
         target    <= next_target;
         port_view <= next_port_view;
      end
   end

   a_watch_none: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && clr |=> target == `RASC_WATCH_NONE)
      else $error("watch target not cleared to none");
   a_watch_wrflag: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && !clr && port_op && !port_hi |=> port_view[8] == $past(port_wr))
      else $error("write flag of low port wrong");
   a_watch_hidata: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && !clr && port_op && port_hi |=> port_view[16:9] == $past(port_data))
      else $error("high port data not stored");
endmodule : rasc_watch

// ==== design/rasc_top.sv ====
// relay array switch control: apb slave, relay state and coil sequencer
// Behaviour
// - slot reset opens every relay on module
// - power-up or system reset opens all relays
// - single channel or channel list per command
// - four wiring modes selected by mode register
// - mode defaults to two-wire after reset
// - one-wire mode allows one closed channel
// - four banks of ten, ten at once
// - coils driven as four rows, ten columns
// - latching relays switched row by row
// - watch query returns target or minus one
// - remember write or read per port
// - high port is low plus one, reported together
// - module insertion or removal forces full reset
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module rasc_top
   import rasc_pkg::*;
#(
   parameter int ROWS = 4,
   parameter int COLS = 10
) (
   // clock and reset
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire logic                    clk_en,
   // apb slave
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [11:0]             paddr,
   input  wire logic [31:0]             pwdata,
   output logic [31:0]                  prdata,
   output logic                         pready,
   output logic                         pslverr,
   // module presence pin
   input  wire logic                    module_present,
   // coil array drive
   output logic [ROWS-1:0]              row_drive,
   output logic [COLS-1:0]              col_drive,
   output logic                         col_close,
   // status
   output logic                         busy
);
`include "rasc_consts.svh"
   localparam int NCH = ROWS * COLS;

   logic [NCH-1:0]  relay;
   logic [NCH-1:0]  next_relay;
   logic [NCH-1:0]  pend;
   logic [NCH-1:0]  next_pend;
   logic            pend_close;
   logic            next_pend_close;
   rasc_mode_t      mode;
   rasc_mode_t      next_mode;
   rasc_state_t     state;
   rasc_state_t     next_state;
   logic [1:0]      row;
   logic [1:0]      next_row;
   logic [7:0]      tick;
   logic [7:0]      next_tick;
   logic            present_s;
   logic            present_d;
   logic            hot_swap;
   logic            all_open;
   logic            wr;
   logic            rd;
   logic            cmd_go;
   logic [COLS-1:0] row_pat;
   logic [NCH-1:0]  cmd_bits;
   logic            set_target;
   logic            port_op;
   logic [31:0]     target;
   logic [17:0]     port_view;
   logic [31:0]     next_prdata;
   logic            mapped;
   logic [NCH-1:0]  chain;
   logic [NCH-1:0]  next_chain;
   logic [2:0]      warm;

   // ------------------------------------------------------------
   // module presence and hot swap reset
   // ------------------------------------------------------------
   rasc_sync u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .clk_en  (clk_en),
      .din     (module_present),
      .dout    (present_s)
   );

   // detector held off until stages hold pin samples, or reset level looks like a swap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         present_d <= 1'b0;
         warm      <= 3'h0;
      end else if (clk_en) begin
         present_d <= present_s;
         warm      <= {warm[1:0], 1'b1};
      end
   end

   assign hot_swap = warm[2] && (present_s ^ present_d);

   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   assign pready  = 1'b1;
   assign wr      = psel && penable && pwrite && clk_en;
   assign rd      = psel && !penable && !pwrite;
   assign mapped  = paddr <= `RASC_OFF_PORTIO && paddr[1:0] == 2'b00;
   assign pslverr = psel && penable && !mapped;

   // system reset, slot reset and hot swap all clear the whole array
   assign all_open = hot_swap
                  || (wr && paddr == `RASC_OFF_CTRL && pwdata[`RASC_CTRL_SYSRST])
                  || (wr && paddr == `RASC_OFF_CTRL && pwdata[`RASC_CTRL_SLOTRST]);
   assign cmd_go = wr && paddr == `RASC_OFF_CMD && pwdata[`RASC_CMD_GO];
   assign set_target = wr && paddr == `RASC_OFF_WATCH;
   assign port_op    = wr && paddr == `RASC_OFF_PORTIO;

   // command payload: channel list mask held in state lo/hi staging
   logic [NCH-1:0] list_mask;
   logic [NCH-1:0] next_list_mask;

   always_comb begin
      next_list_mask = list_mask;
      if (wr && paddr == `RASC_OFF_STATE_LO) begin
         next_list_mask[31:0] = pwdata;
      end
      if (wr && paddr == `RASC_OFF_STATE_HI) begin
         next_list_mask[NCH-1:32] = pwdata[NCH-33:0];
      end
      if (all_open) begin
         next_list_mask = '0;
      end
   end

   // a one-wire close keeps only the lowest requested channel
   always_comb begin
      cmd_bits = list_mask;
      if (mode == one_wire_mode && pwdata[`RASC_CMD_CLOSE]) begin
         cmd_bits = list_mask & (~list_mask + NCH'(1));
      end
   end

   // ------------------------------------------------------------
   // relay state, mode and bank sequencer
   // ------------------------------------------------------------
   always_comb begin
      next_relay      = relay;
      next_pend       = pend;
      next_pend_close = pend_close;
      next_mode       = mode;
      next_state      = state;
      next_row        = row;
      next_tick       = tick;
      next_chain      = chain;
      if (wr && paddr == `RASC_OFF_MODE && state == RASC_IDLE
          && (|pwdata[1:0] || $onehot0(relay))) begin
         next_mode = rasc_mode_t'(pwdata[1:0]);
      end
      case (state)
         RASC_IDLE: begin
            if (cmd_go) begin
               next_pend       = cmd_bits;
               next_pend_close = pwdata[`RASC_CMD_CLOSE];
               next_row        = `RASC_ROW_ZERO;
               if (mode == one_wire_mode && pwdata[`RASC_CMD_CLOSE] && |cmd_bits
                   && |(relay & ~cmd_bits)) begin
                  next_pend       = relay & ~cmd_bits;
                  next_pend_close = 1'b0;
                  next_chain      = cmd_bits;
               end
               next_state = RASC_SETUP;
            end
         end
         RASC_SETUP: begin
            // skip banks with no work so only touched rows get a pulse
            if (|row_pat) begin
               next_tick  = `RASC_COIL_PULSE;
               next_state = RASC_DRIVE;
            end else begin
               next_state = RASC_NEXT;
            end
         end
         RASC_DRIVE: begin
            next_tick = tick - 8'h01;
            if (tick == 8'h01) begin
               for (int c = 0; c < COLS; c++) begin
                  if (row_pat[c]) begin
                     next_relay[int'(row) * COLS + c] = pend_close;
                  end
               end
               next_state = RASC_NEXT;
            end
         end
         RASC_NEXT: begin
            if (row == 2'(ROWS - 1) && |chain) begin
               next_pend       = chain;
               next_pend_close = 1'b1;
               next_chain      = '0;
               next_row        = `RASC_ROW_ZERO;
               next_state      = RASC_SETUP;
            end else if (row == 2'(ROWS - 1)) begin
               next_pend  = '0;
               next_state = RASC_IDLE;
            end else begin
               next_row   = row + 2'h1;
               next_state = RASC_SETUP;
            end
         end
         default: begin
            next_state = RASC_IDLE;
         end
      endcase
      if (all_open) begin
         next_pend       = relay | pend;
         next_pend_close = 1'b0;
         next_chain      = '0;
         next_row        = `RASC_ROW_ZERO;
         next_state      = RASC_SETUP;
         next_mode  = rasc_mode_t'(`RASC_MODE_RESET);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         relay      <= '0;
         pend       <= '0;
         pend_close <= 1'b0;
         mode       <= rasc_mode_t'(`RASC_MODE_RESET);
         state      <= RASC_IDLE;
         row        <= `RASC_ROW_ZERO;
         tick       <= 8'h00;
         list_mask  <= '0;
         chain      <= '0;
      end else if (clk_en) begin
         relay      <= next_relay;
         pend       <= next_pend;
         pend_close <= next_pend_close;
         mode       <= next_mode;
         state      <= next_state;
         row        <= next_row;
         tick       <= next_tick;
         list_mask  <= next_list_mask;
         chain      <= next_chain;
      end
   end

   // ------------------------------------------------------------
   // coil array drive
   // ------------------------------------------------------------
   // column pattern of the bank under service
   assign row_pat = pend[int'(row) * COLS +: COLS];

   // row lines asserted only while the bank's columns are applied
   for (genvar r = 0; r < ROWS; r++) begin : g_row
      assign row_drive[r] = (state == RASC_DRIVE) && (row == 2'(r));
   end
   assign col_drive = (state == RASC_DRIVE) ? row_pat : '0;
   assign col_close = (state == RASC_DRIVE) && pend_close;
   assign busy      = state != RASC_IDLE;

   // ------------------------------------------------------------
   // channel watch
   // ------------------------------------------------------------
   rasc_watch u_watch (
      .pclk       (pclk),
      .presetn    (presetn),
      .clk_en     (clk_en),
      .clr        (all_open),
      .set_target (set_target),
      .target_in  (pwdata),
      .port_op    (port_op),
      .port_hi    (pwdata[16]),
      .port_wr    (pwdata[8]),
      .port_data  (pwdata[7:0]),
      .target     (target),
      .port_view  (port_view)
   );

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   always_comb begin
      next_prdata = prdata;
      if (rd) begin
         case (paddr)
            `RASC_OFF_MODE:     next_prdata = {30'h0000_0000, mode};
            `RASC_OFF_STATUS:   next_prdata = {31'h0000_0000, busy};
            `RASC_OFF_STATE_LO: next_prdata = relay[31:0];
            `RASC_OFF_STATE_HI: next_prdata = {24'h00_0000, relay[NCH-1:32]};
            `RASC_OFF_WATCH:    next_prdata = target;
            `RASC_OFF_WDATA:    next_prdata = {14'h0000, port_view};
            default:            next_prdata = 32'h0000_0000;
         endcase
      end
   end

   // read data is registered at the end of the setup cycle so it stands through the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (clk_en) begin
         prdata <= next_prdata;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_reset_opens: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && all_open |-> ##[1:25] relay == '0)
      else $error("reset did not open relays");
   a_mode_default: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && all_open |=> mode == two_wire_mode)
      else $error("mode not back to two-wire");
   a_one_wire: assert property (@(posedge pclk) disable iff (!presetn)
      mode == one_wire_mode && state == RASC_IDLE |-> $onehot0(relay))
      else $error("more than one relay closed in one-wire mode");
   a_row_onehot: assert property (@(posedge pclk) disable iff (!presetn)
      $onehot0(row_drive))
      else $error("several rows driven at once");
   a_row_with_cols: assert property (@(posedge pclk) disable iff (!presetn)
      |row_drive |-> |col_drive)
      else $error("row driven without column pattern");
   a_hot_swap: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && hot_swap |-> ##[1:25] (relay == '0 && !busy))
      else $error("hot swap did not reset");
   a_drive_len: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(state == RASC_DRIVE) && clk_en |-> (state == RASC_DRIVE)[*4])
      else $error("coil pulse too short");
   a_list_done: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && cmd_go && state == RASC_IDLE |-> ##[1:49] state == RASC_IDLE)
      else $error("channel list not finished");
endmodule : rasc_top

// ==== dv/rasc_relay_model.sv ====
// behavioural latching relay array seen through the row and column coil lines
`timescale 1ns/1ps
module rasc_relay_model (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // coil lines
   input  wire logic [3:0]  row_drive,
   input  wire logic [9:0]  col_drive,
   input  wire logic        col_close,
   // observed state
   output logic      [39:0] relays,
   output int               bad_rows
);
   // ----------
   // coil array
   // ----------
   // a relay moves only where its row and its column are both energised;
   // latching parts keep their contact when the coils go quiet
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         relays   <= '0;
         bad_rows <= 0;
      end else begin
         // two rows at once or a row without columns is a drive fault
         if ($countones(row_drive) > 1 || (row_drive != 4'h0 && col_drive == 10'h000)) begin
            bad_rows <= bad_rows + 1;
         end
         for (int r = 0; r < 4; r++) begin
            for (int c = 0; c < 10; c++) begin
               if (row_drive[r] && col_drive[c]) begin
                  relays[r*10+c] <= col_close;
               end
            end
         end
      end
   end
endmodule : rasc_relay_model

// ==== dv/relay_array_switch_control_bench.sv ====
// self-checking testbench for the relay array switch control block
`timescale 1ns/1ps
`include "rasc_consts.svh"
module relay_array_switch_control_bench import rasc_pkg::*;;
   // ----------
   // signals
   // ----------
   logic        pclk, presetn, clk_en, psel, penable, pwrite, module_present;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rv;
   logic        pready, pslverr, col_close, busy, err;
   logic [3:0]  row_drive;
   logic [9:0]  col_drive;
   logic [39:0] relays;
   int          bad_rows, failures, n_checks;

   rasc_top #(.ROWS(4), .COLS(10)) i_dut (
      .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .module_present(module_present), .row_drive(row_drive),
      .col_drive(col_drive), .col_close(col_close), .busy(busy));

   rasc_relay_model i_relays (
      .pclk(pclk), .presetn(presetn), .row_drive(row_drive),
      .col_drive(col_drive), .col_close(col_close), .relays(relays),
      .bad_rows(bad_rows));

   // 100 MHz clock
   always #5 pclk = ~pclk;

   // ----------
   // apb master and checks
   // ----------
   // read data and error are taken at the edge that samples pready high
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'h1;
      penable <= 1'h0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) begin
         @(posedge pclk);
      end
      rv = prdata;
      err = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask : xfer

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'h1, a, d);
   endtask : wr

   // read data is loaded at the setup edge and stands through the access edge
   task automatic rd(input logic [11:0] a);
      xfer(1'h0, a, 32'h0000_0000);
   endtask : rd

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
      rd(a);
      chk(nm, rv, exp);
   endtask : rdchk

   // relay state through the registers and, optionally, at the coils
   task automatic st(input logic [39:0] e, input logic coils);
      rdchk("state_lo", `RASC_OFF_STATE_LO, e[31:0]);
      rdchk("state_hi", `RASC_OFF_STATE_HI, {24'h00_0000, e[39:32]});
      if (coils) begin
         chk("coils_lo", relays[31:0], e[31:0]);
         chk("coils_hi", {24'h00_0000, relays[39:32]}, {24'h00_0000, e[39:32]});
         chk("row_faults", 32'(bad_rows), 32'h0000_0000);
      end
   endtask : st

   // channel list command, then a bounded wait for the sequencer
   task automatic go(input logic [39:0] m, input logic cl);
      wr(`RASC_OFF_STATE_LO, m[31:0]);
      wr(`RASC_OFF_STATE_HI, {24'h00_0000, m[39:32]});
      wr(`RASC_OFF_CMD, {30'h0000_0000, 1'h1, cl});
      idle();
   endtask : go

   // bounded wait for the sequencer, then status must read idle
   task automatic idle();
      @(posedge pclk);
      for (int i = 0; i < 100 && busy !== 1'h0; i++) begin
         @(posedge pclk);
      end
      rdchk("status", `RASC_OFF_STATUS, 32'h0000_0000);
   endtask : idle

   task automatic done(input string s);
      $display("test %s finished", s);
   endtask : done

   task automatic end_sim();
      $display("comparisons %0d, mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_sim

   // ----------
   // watchdog
   // ----------
   // the whole sequence needs well under a thousand cycles
   initial begin
      repeat (20000) @(posedge pclk);
      failures++;
      end_sim();
   end

   // ----------
   // tests
   // ----------
   initial begin
      pclk = 1'h0; presetn = 1'h0; clk_en = 1'h1; psel = 1'h0; penable = 1'h0;
      pwrite = 1'h0; paddr = 12'h000; pwdata = 32'h0000_0000; module_present = 1'h1;
      failures = 0; n_checks = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'h1;
      rdchk("mode", `RASC_OFF_MODE, {30'h0000_0000, two_wire_mode});
      st(40'h00_0000_0000, 1'h1);
      rdchk("watch", `RASC_OFF_WATCH, 32'hFFFF_FFFF);
      done("reset");
      // a write while the clock enable is low must leave no trace
      clk_en <= 1'h0;
      wr(`RASC_OFF_MODE, {30'h0000_0000, four_wire_mode});
      clk_en <= 1'h1;
      rdchk("mode", `RASC_OFF_MODE, {30'h0000_0000, two_wire_mode});
      for (int m = 0; m < 4; m++) begin
         wr(`RASC_OFF_MODE, 32'(m));
         rdchk("mode", `RASC_OFF_MODE, 32'(m));
      end
      wr(`RASC_OFF_MODE, {30'h0000_0000, two_wire_mode});
      done("modes");
      // four banks at once, bank 2 with all ten relays
      go(40'h80_BFF0_8201, 1'h1);
      st(40'h80_BFF0_8201, 1'h1);
      go(40'h00_0000_0201, 1'h0);
      st(40'h80_BFF0_8000, 1'h1);
      done("banks");
      // one-wire is refused while several relays are closed
      wr(`RASC_OFF_MODE, {30'h0000_0000, one_wire_mode});
      rdchk("mode", `RASC_OFF_MODE, {30'h0000_0000, two_wire_mode});
      go(40'h80_BFF0_8000, 1'h0);
      // one-wire: only the lowest listed channel may stay closed
      wr(`RASC_OFF_MODE, {30'h0000_0000, one_wire_mode});
      go(40'h00_0010_0020, 1'h1);
      st(40'h00_0000_0020, 1'h1);
      go(40'h00_0000_0080, 1'h1);
      st(40'h00_0000_0080, 1'h1);
      done("one_wire");
      wr(`RASC_OFF_CTRL, 32'h0000_0001);
      idle();
      st(40'h00_0000_0000, 1'h1);
      rdchk("mode", `RASC_OFF_MODE, {30'h0000_0000, two_wire_mode});
      wr(`RASC_OFF_WATCH, 32'h0000_0067);
      rdchk("watch", `RASC_OFF_WATCH, 32'h0000_0067);
      go(40'h00_0000_0004, 1'h1);
      wr(`RASC_OFF_MODE, {30'h0000_0000, four_wire_mode});
      wr(`RASC_OFF_CTRL, 32'h0000_0002);
      idle();
      st(40'h00_0000_0000, 1'h1);
      rdchk("mode", `RASC_OFF_MODE, {30'h0000_0000, two_wire_mode});
      rdchk("watch", `RASC_OFF_WATCH, 32'hFFFF_FFFF);
      done("resets");
      // low port written with FE, high port read as FF, then high written
      wr(`RASC_OFF_PORTIO, 32'h0000_01FE);
      wr(`RASC_OFF_PORTIO, 32'h0001_00FF);
      rdchk("ports", `RASC_OFF_WDATA, 32'h0001_FFFE);
      wr(`RASC_OFF_PORTIO, 32'h0001_0112);
      rdchk("ports", `RASC_OFF_WDATA, 32'h0002_25FE);
      done("watch_ports");
      // pulling the module must reset as a whole
      go(40'h00_0000_0002, 1'h1);
      wr(`RASC_OFF_MODE, {30'h0000_0000, dual_two_wire_mode});
      module_present <= 1'h0;
      rd(`RASC_OFF_STATE_LO);
      for (int i = 0; i < 10 && rv !== 32'h0000_0000; i++) begin
         rd(`RASC_OFF_STATE_LO);
      end
      chk("state_lo", rv, 32'h0000_0000);
      rdchk("mode", `RASC_OFF_MODE, {30'h0000_0000, two_wire_mode});
      module_present <= 1'h1;
      done("presence");
      rd(12'h040);
      chk("slverr", {31'h0000_0000, err}, 32'h0000_0001);
      chk("unmapped", rv, 32'h0000_0000);
      done("unmapped");
      end_sim();
   end
endmodule : relay_array_switch_control_bench
